// >>> pcdb_clock_output_pin.sv
// Output stage that drives the observation clock onto the clock output pin
`timescale 1ns/10ps
`default_nettype none

module pcdb_clock_output_pin (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic obs_clk_i,
  output logic pin_o
);

  logic pin_r;

  // Final flop keeps pin free of combinational hazards
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= obs_clk_i;
    end
  end

  assign pin_o = pin_r;

endmodule
`default_nettype wire

// >>> pcdb_consts.svh
// Register map, field layout, reset values and bus codes of the divider bank
`ifndef PCDB_CONSTS_SVH
`define PCDB_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PCDB_OFS_MAIN_DIV3 8'h00
`define PCDB_OFS_MAIN_DIV4 8'h04
`define PCDB_OFS_MAIN_DIV5 8'h08
`define PCDB_OFS_MAIN_DIV6 8'h0c
`define PCDB_OFS_MAIN_DIV7 8'h10
`define PCDB_OFS_AUX_DIV3 8'h14
`define PCDB_OFS_OBS_DIV 8'h18
`define PCDB_OFS_GATE_CTRL 8'h1c
`define PCDB_OFS_STATUS 8'h20

// ----------------------------------------------------------------------------
// Channel indices and field layout
// ----------------------------------------------------------------------------
`define PCDB_NUM_CH 7
`define PCDB_CH_AUX3 5
`define PCDB_CH_OBS 6
`define PCDB_RATIO_MSB 4
`define PCDB_RATIO_LSB 0
`define PCDB_EN_BIT 15
`define PCDB_GATE_OBS_BIT 1
`define PCDB_STAT_LEVEL_LSB 0
`define PCDB_STAT_PEND_LSB 16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PCDB_RST_RATIO_D3 5'h02
`define PCDB_RST_RATIO_D4 5'h03
`define PCDB_RST_RATIO_D5 5'h02
`define PCDB_RST_RATIO_D6 5'h00
`define PCDB_RST_RATIO_D7 5'h05
`define PCDB_RST_RATIO_OBS 5'h00
`define PCDB_RST_EN_SYS 1'b1
`define PCDB_RST_EN_OBS 1'b0
`define PCDB_RST_GATE_OBS 1'b0
`define PCDB_ZERO_RATIO 5'h00
`define PCDB_CNT_ONE 5'h01
`define PCDB_HALF_ONE 6'h01

// ----------------------------------------------------------------------------
// Avalon-MM response codes
// ----------------------------------------------------------------------------
`define PCDB_RESP_OK 2'h0
`define PCDB_RESP_DECERR 2'h3
`define PCDB_WORD_ZERO 32'h0000_0000

`endif

// >>> pcdb_div.sv
// One glitch-free programmable divider clocked by the reference clock
`timescale 1ns/10ps
`default_nettype none
`include "pcdb_consts.svh"

module pcdb_div (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic src_i,
  input wire pcdb_pkg::pcdb_div_cfg_t cfg_i,
  output logic clk_o,
  output logic pending_o
);

  logic src_q_r;
  logic [4:0] cnt_r, cnt_nxt;
  logic [4:0] act_r, act_nxt;
  logic en_r, en_nxt;
  logic out_r, out_nxt;
  wire logic rise = src_i & ~src_q_r;
  wire logic wrap = (cnt_r == act_r);
  wire logic [5:0] half = ({1'b0, act_nxt} + `PCDB_HALF_ONE) >> 1;

  // --------------------------------------------------------------------------
  // Period counter; new settings load only at a period boundary
  // --------------------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    en_nxt = en_r;
    if (rise) begin
      if (wrap) begin
        cnt_nxt = `PCDB_ZERO_RATIO;
        act_nxt = cfg_i.ratio;
        en_nxt = cfg_i.en;
      end else begin
        cnt_nxt = cnt_r + `PCDB_CNT_ONE;
      end
    end
    out_nxt = out_r;
    if (!en_nxt) begin
      out_nxt = 1'b0;
    end else if (act_nxt == `PCDB_ZERO_RATIO) begin
      out_nxt = src_i;
    end else if (rise) begin
      out_nxt = ({1'b0, cnt_nxt} < half);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      src_q_r <= 1'b0;
      cnt_r <= `PCDB_ZERO_RATIO;
      act_r <= `PCDB_ZERO_RATIO;
      en_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      src_q_r <= src_i;
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
      en_r <= en_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_o = out_r;
  assign pending_o = (act_r != cfg_i.ratio) | (en_r != cfg_i.en);

endmodule
`default_nettype wire

// >>> pcdb_pkg.sv
// Types shared by the divider bank modules
package pcdb_pkg;

  typedef struct packed {
    logic en;
    logic [4:0] ratio;
  } pcdb_div_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be;
  } pcdb_bus_req_t;

  typedef enum logic {
    pcdb_st_idle,
    pcdb_st_ack
  } pcdb_bus_state_t;

endpackage

// >>> pcdb_top.sv
// Post-PLL divider bank with its Avalon-MM register slave
//
// Contract
// - Each divider divides its input by its 5-bit ratio field plus one.
// - Bit 15 of each system divider register enables it; zero disables.
// - Divider 3 of main and aux controllers resets to ratio 2.
// - Main divider 4 resets to ratio 3.
// - Main divider 5 resets to ratio 2.
// - Main divider 6 resets to ratio 0, passing the PLL clock.
// - Main divider 7 resets to ratio 5.
// - Main dividers 3-7 make main clocks 3-7; aux divider 3 makes aux clock 3.
// - Observation divider divides the selected observation source clock.
// - Observation clock drives the clock output pin directly; the code passes it through one more ref_clk_i flop, one cycle late.
// - Observation clock toggles only when its divider and gate enables are set.
// - Observation divider has enable bit 15, ratio bits 4-0; zero passes through.
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pcdb_consts.svh"

module pcdb_top (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic pll_main_clk_i,
  input wire logic pll_aux_clk_i,
  input wire logic obs_src_clk_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  output logic main_system_clock3_o,
  output logic main_system_clock4_o,
  output logic main_system_clock5_o,
  output logic main_system_clock6_o,
  output logic main_system_clock7_o,
  output logic aux_system_clock3_o,
  output logic clock_output_pin_o
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // Divider register image; reserved bits always zero
  function automatic logic [31:0] ctrl_image(input pcdb_pkg::pcdb_div_cfg_t cfg);
    logic [31:0] img;
    img = `PCDB_WORD_ZERO;
    img[`PCDB_EN_BIT] = cfg.en;
    img[`PCDB_RATIO_MSB:`PCDB_RATIO_LSB] = cfg.ratio;
    return img;
  endfunction

  // Offset to channel index; returns NUM_CH when no divider is hit
  function automatic logic [2:0] ch_index(input logic [7:0] addr);
    logic [2:0] idx;
    idx = 3'(`PCDB_NUM_CH);
    case (addr)
      `PCDB_OFS_MAIN_DIV3: idx = 3'h0;
      `PCDB_OFS_MAIN_DIV4: idx = 3'h1;
      `PCDB_OFS_MAIN_DIV5: idx = 3'h2;
      `PCDB_OFS_MAIN_DIV6: idx = 3'h3;
      `PCDB_OFS_MAIN_DIV7: idx = 3'h4;
      `PCDB_OFS_AUX_DIV3: idx = 3'(`PCDB_CH_AUX3);
      `PCDB_OFS_OBS_DIV: idx = 3'(`PCDB_CH_OBS);
      default: idx = 3'(`PCDB_NUM_CH);
    endcase
    return idx;
  endfunction

  // Reset configuration of one channel
  function automatic pcdb_pkg::pcdb_div_cfg_t rst_cfg(input int ch);
    pcdb_pkg::pcdb_div_cfg_t c;
    c.en = `PCDB_RST_EN_SYS;
    case (ch)
      0: c.ratio = `PCDB_RST_RATIO_D3;
      1: c.ratio = `PCDB_RST_RATIO_D4;
      2: c.ratio = `PCDB_RST_RATIO_D5;
      3: c.ratio = `PCDB_RST_RATIO_D6;
      4: c.ratio = `PCDB_RST_RATIO_D7;
      `PCDB_CH_AUX3: c.ratio = `PCDB_RST_RATIO_D3;
      default: begin
        c.ratio = `PCDB_RST_RATIO_OBS;
        c.en = `PCDB_RST_EN_OBS;
      end
    endcase
    return c;
  endfunction

  // --------------------------------------------------------------------------
  // Bus request capture and decode
  // --------------------------------------------------------------------------
  pcdb_pkg::pcdb_bus_req_t req;
  pcdb_pkg::pcdb_bus_state_t state_r, state_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] resp_r, resp_nxt;

  // One driver for the whole struct; field order follows the package
  assign req = {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, avs_byteenable_i};

  wire logic [2:0] sel_ch = ch_index(req.addr);
  wire logic hit_div = (sel_ch != 3'(`PCDB_NUM_CH));
  wire logic hit_gate = (req.addr == `PCDB_OFS_GATE_CTRL);
  wire logic hit_stat = (req.addr == `PCDB_OFS_STATUS);
  wire logic hit_any = hit_div | hit_gate | hit_stat;
  wire logic req_any = req.rd | req.wr;
  // Commit happens on the edge that sees waitrequest low
  wire logic commit = (state_r == pcdb_pkg::pcdb_st_ack) & req.wr;
  wire logic wr_ratio = commit & req.be[0];
  wire logic wr_en = commit & req.be[1];

  // --------------------------------------------------------------------------
  // Configuration storage
  // --------------------------------------------------------------------------
  pcdb_pkg::pcdb_div_cfg_t cfg_r [`PCDB_NUM_CH];
  pcdb_pkg::pcdb_div_cfg_t cfg_nxt [`PCDB_NUM_CH];
  logic gate_obs_r, gate_obs_nxt;

  always_comb begin
    for (int i = 0; i < `PCDB_NUM_CH; i++) begin
      cfg_nxt[i] = cfg_r[i];
      if (hit_div && (sel_ch == 3'(i))) begin
        if (wr_ratio) begin
          cfg_nxt[i].ratio = req.wdata[`PCDB_RATIO_MSB:`PCDB_RATIO_LSB];
        end
        if (wr_en) begin
          cfg_nxt[i].en = req.wdata[`PCDB_EN_BIT];
        end
      end
    end
  end

  assign gate_obs_nxt = (hit_gate && commit && req.be[0]) ? req.wdata[`PCDB_GATE_OBS_BIT] : gate_obs_r;

  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < `PCDB_NUM_CH; i++) begin
      if (sys_rst_i) begin
        cfg_r[i] <= rst_cfg(i);
      end else begin
        cfg_r[i] <= cfg_nxt[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      gate_obs_r <= `PCDB_RST_GATE_OBS;
    end else begin
      gate_obs_r <= gate_obs_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Divider channels
  // --------------------------------------------------------------------------
  logic [`PCDB_NUM_CH-1:0] ch_src;
  logic [`PCDB_NUM_CH-1:0] ch_clk;
  logic [`PCDB_NUM_CH-1:0] ch_pend;
  pcdb_pkg::pcdb_div_cfg_t ch_cfg [`PCDB_NUM_CH];

  always_comb begin
    for (int i = 0; i < `PCDB_NUM_CH; i++) begin
      ch_src[i] = pll_main_clk_i;
      ch_cfg[i] = cfg_r[i];
    end
    ch_src[`PCDB_CH_AUX3] = pll_aux_clk_i;
    ch_src[`PCDB_CH_OBS] = obs_src_clk_i;
    // Gate joins the enable so it also switches only at a period boundary
    ch_cfg[`PCDB_CH_OBS].en = cfg_r[`PCDB_CH_OBS].en & gate_obs_r;
  end

  for (genvar g = 0; g < `PCDB_NUM_CH; g++) begin : g_ch
    pcdb_div u_div (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .src_i(ch_src[g]),
      .cfg_i(ch_cfg[g]),
      .clk_o(ch_clk[g]),
      .pending_o(ch_pend[g])
    );
  end

  pcdb_clock_output_pin u_clock_output_pin (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .obs_clk_i(ch_clk[`PCDB_CH_OBS]),
    .pin_o(clock_output_pin_o)
  );

  // Divider outputs are flop outputs inside each channel
  assign main_system_clock3_o = ch_clk[0];
  assign main_system_clock4_o = ch_clk[1];
  assign main_system_clock5_o = ch_clk[2];
  assign main_system_clock6_o = ch_clk[3];
  assign main_system_clock7_o = ch_clk[4];
  assign aux_system_clock3_o = ch_clk[`PCDB_CH_AUX3];

  // --------------------------------------------------------------------------
  // Read-back
  // --------------------------------------------------------------------------
  logic [31:0] stat_word;
  logic [31:0] gate_word;
  logic [31:0] rd_mux;

  always_comb begin
    stat_word = `PCDB_WORD_ZERO;
    stat_word[`PCDB_STAT_LEVEL_LSB +: `PCDB_NUM_CH] = ch_clk;
    // Pending: written setting not yet taken up at a period boundary
    stat_word[`PCDB_STAT_PEND_LSB +: `PCDB_NUM_CH] = ch_pend;
    gate_word = `PCDB_WORD_ZERO;
    gate_word[`PCDB_GATE_OBS_BIT] = gate_obs_r;
  end

  always_comb begin
    rd_mux = `PCDB_WORD_ZERO;
    if (hit_div) begin
      rd_mux = ctrl_image(cfg_r[sel_ch]);
    end else if (hit_gate) begin
      rd_mux = gate_word;
    end else if (hit_stat) begin
      rd_mux = stat_word;
    end
  end

  // --------------------------------------------------------------------------
  // Avalon-MM handshake: one wait cycle, then answer
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    rdata_nxt = rdata_r;
    resp_nxt = resp_r;
    case (state_r)
      pcdb_pkg::pcdb_st_idle: begin
        if (req_any) begin
          state_nxt = pcdb_pkg::pcdb_st_ack;
          wait_nxt = 1'b0;
          rdata_nxt = req.rd ? rd_mux : `PCDB_WORD_ZERO;
          resp_nxt = hit_any ? `PCDB_RESP_OK : `PCDB_RESP_DECERR;
        end
      end
      pcdb_pkg::pcdb_st_ack: begin
        state_nxt = pcdb_pkg::pcdb_st_idle;
        wait_nxt = 1'b1;
      end
      default: begin
        state_nxt = pcdb_pkg::pcdb_st_idle;
        wait_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_r <= pcdb_pkg::pcdb_st_idle;
      wait_r <= 1'b1;
      rdata_r <= `PCDB_WORD_ZERO;
      resp_r <= `PCDB_RESP_OK;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      resp_r <= resp_nxt;
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;
  assign avs_response_o = resp_r;

endmodule
`default_nettype wire

// >>> pcdb_top_sva.sv
// Port-level assertions for the divider bank
`timescale 1ns/10ps
`default_nettype none
`include "pcdb_consts.svh"
module pcdb_top_sva (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic pll_main_clk_i,
  input wire logic pll_aux_clk_i,
  input wire logic obs_src_clk_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  input wire logic main_system_clock3_o,
  input wire logic main_system_clock4_o,
  input wire logic main_system_clock5_o,
  input wire logic main_system_clock6_o,
  input wire logic main_system_clock7_o,
  input wire logic aux_system_clock3_o,
  input wire logic clock_output_pin_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----
  // Sticky flag: gate bit ever written as one
  // ----
  logic gate_seen_r;
  wire gate_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == `PCDB_OFS_GATE_CTRL;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) gate_seen_r <= 1'b0;
    else if (gate_wr && avs_byteenable_i[0] && avs_writedata_i[1]) gate_seen_r <= 1'b1;
  end
  property p_ack; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  property p_rsv; !avs_waitrequest_o && avs_read_i && avs_address_i < `PCDB_OFS_GATE_CTRL
    |-> avs_readdata_o[31:16] == 16'h0000 && avs_readdata_o[14:5] == 10'h000; endproperty
  property p_dec; avs_read_i && avs_waitrequest_o && avs_address_i > 8'h23
    |=> avs_response_o == `PCDB_RESP_DECERR && avs_readdata_o == `PCDB_WORD_ZERO; endproperty
  property p_m3; $rose(main_system_clock3_o) |-> $past(pll_main_clk_i); endproperty
  property p_a3; $rose(aux_system_clock3_o) |-> $past(pll_aux_clk_i); endproperty
  property p_pin; $rose(clock_output_pin_o) |-> $past(obs_src_clk_i, 2); endproperty
  property p_gate; !gate_seen_r |-> !clock_output_pin_o; endproperty
  property p_m4w; $rose(main_system_clock4_o) |=> main_system_clock4_o; endproperty
  property p_rst; $fell(sys_rst_i) |-> avs_waitrequest_o && !main_system_clock6_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack one cycle after request");
  a_one: assert property (p_one) else $error("ack longer than one cycle");
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  a_dec: assert property (p_dec) else $error("unmapped read not refused");
  a_m3: assert property (p_m3) else $error("main clock 3 rose without source");
  a_a3: assert property (p_a3) else $error("aux clock 3 rose without source");
  a_pin: assert property (p_pin) else $error("output pin rose without source");
  a_gate: assert property (p_gate) else $error("output pin toggled while gated");
  a_m4w: assert property (p_m4w) else $error("short pulse on main clock 4");
  a_rst: assert property (p_rst) else $error("bad state after reset");
  c_dec: cover property (avs_read_i && !avs_waitrequest_o && avs_response_o == `PCDB_RESP_DECERR);
  c_pin: cover property ($rose(clock_output_pin_o));
  c_m4: cover property ($rose(main_system_clock4_o));
endmodule
bind pcdb_top pcdb_top_sva u_sva (.*);
`default_nettype wire

// >>> test_pll_sysclk_divider_bank.sv
// Self-checking bench for the divider bank
`timescale 1ns/10ps
`default_nettype none
`include "pcdb_consts.svh"
module test_pll_sysclk_divider_bank;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, pll_main_clk_i = 1'b0, pll_aux_clk_i = 1'b0, obs_src_clk_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] avs_response_o;
  logic main_system_clock3_o, main_system_clock4_o, main_system_clock5_o, main_system_clock6_o;
  logic main_system_clock7_o, aux_system_clock3_o, clock_output_pin_o;
  typedef struct packed {logic rd; logic [31:0] d; logic [1:0] r;} pcdb_note_t;
  pcdb_note_t notes[$];
  pcdb_note_t nt;
  int failures = 0, checks_done = 0, ph = 0, i;
  logic [31:0] seed, rnd;
  logic [4:0] rt;
  logic [31:0] rv[7] = '{32'h8002, 32'h8003, 32'h8002, 32'h8000, 32'h8005, 32'h8002, 32'h0000};
  int pe[6] = '{12, 16, 12, 4, 24, 18};
  wire [6:0] ck = {clock_output_pin_o, aux_system_clock3_o, main_system_clock7_o, main_system_clock6_o,
    main_system_clock5_o, main_system_clock4_o, main_system_clock3_o};
  pcdb_top dut (.*);
  always #2.5 ref_clk_i = !ref_clk_i;
  // Source clocks of 4, 6 and 8 ref periods
  always @(posedge ref_clk_i) begin
    ph <= ph + 1;
    if (ph % 2 == 0) pll_main_clk_i <= !pll_main_clk_i;
    if (ph % 3 == 0) pll_aux_clk_i <= !pll_aux_clk_i;
    if (ph % 4 == 0) obs_src_clk_i <= !obs_src_clk_i;
  end
  task final_report;
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task fail(input string m);
    failures++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  // ----
  // Bus results checked against the oldest note
  // ----
  always @(posedge ref_clk_i) begin
    if (!sys_rst_i && avs_waitrequest_o === 1'b0) begin
      if (notes.size() == 0) fail("ack without request");
      else begin
        nt = notes.pop_front();
        checks_done++;
        if (avs_response_o !== nt.r || (nt.rd && avs_readdata_o !== nt.d)) fail("bus result");
      end
    end
  end
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
    input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge ref_clk_i);
    notes.push_back('{!wr, ed, er});
    avs_address_i <= a;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) begin
      fail("bus timeout");
      final_report();
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hf, e, `PCDB_RESP_OK);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be, 32'h0000_0000, `PCDB_RESP_OK);
  endtask
  task rise(input int k, inout int n);
    while (ck[k] !== 1'b0 && n < 400) begin
      @(posedge ref_clk_i);
      n++;
    end
    while (ck[k] !== 1'b1 && n < 400) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 400) begin
      fail("clock stuck");
      final_report();
    end
  endtask
  // Skips two edges so a pending ratio has landed
  task period(input int k, input int e);
    int n;
    n = 0;
    rise(k, n);
    n = 0;
    rise(k, n);
    n = 0;
    rise(k, n);
    checks_done++;
    if (n != e) fail("clock period");
  endtask
  task low(input int k);
    int h;
    h = 0;
    repeat (60) @(posedge ref_clk_i);
    repeat (60) begin
      @(posedge ref_clk_i);
      if (ck[k] !== 1'b0) h++;
    end
    checks_done++;
    if (h != 0) fail("clock not held low");
  endtask
  initial begin
    seed = 32'h2f22c42d;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (i = 0; i < 7; i++) rd(8'(4 * i), rv[i]);
    for (i = 0; i < 6; i++) period(i, pe[i]);
    wr(8'h04, 32'hffff_ffff, 4'hf);
    rd(8'h04, 32'h0000_801f);
    period(1, 128);
    repeat (3) begin
      rnd = $random(seed);
      rt = {2'b00, rnd[2:0]};
      wr(8'h08, {rnd[31:16], 1'b1, rnd[14:5], rt}, 4'hf);
      rd(8'h08, {16'h0000, 1'b1, 10'h000, rt});
      period(2, 4 * (int'(rt) + 1));
    end
    wr(8'h10, 32'h0000_0005, 4'hf);
    rd(8'h10, 32'h0000_0005);
    low(4);
    wr(8'h10, 32'h0000_8000, 4'h2);
    rd(8'h10, 32'h0000_8005);
    period(4, 24);
    wr(8'h00, 32'h0000_0004, 4'h1);
    rd(8'h00, 32'h0000_8004);
    wr(8'h14, 32'h0000_8001, 4'hf);
    period(5, 12);
    low(6);
    wr(8'h18, 32'h0000_8000, 4'hf);
    low(6);
    wr(8'h1c, 32'h0000_0002, 4'h1);
    rd(8'h1c, 32'h0000_0002);
    period(6, 8);
    wr(8'h18, 32'h0000_8002, 4'hf);
    period(6, 24);
    wr(8'h1c, 32'h0000_0000, 4'h1);
    low(6);
    bus(1'b0, 8'h40, 32'h0000_0000, 4'hf, 32'h0000_0000, `PCDB_RESP_DECERR);
    bus(1'b1, 8'h44, 32'hffff_ffff, 4'hf, 32'h0000_0000, `PCDB_RESP_DECERR);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h04, 32'h0000_8003);
    final_report();
  end
endmodule
`default_nettype wire
